// [rtl/emp_match_port.sv]
// external address match port: frame tracking, compare handshake, learn and strip
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - copy and own-source are captured on first byte edge after compare drops
// - a compare counts only if raised before the seventh info byte
// - no copy if compare still active two byte times after ending delimiter
// - compare may idle high or low; either pulse polarity works
// - a raised compare governs the copy even outside external copy mode
// - a sampled copy request copies the frame when resources allow
// - destination match sampled one byte before ring engine sees delimiter
// - own-source match starts stripping three byte times later
// - learn asserts for long-address frames not sent by this station
// - learn held false from transparent send until own void returns
// - learn valid three byte times after fourth info byte arrives
// - suppress before seventh info byte blocks the internal match flag
// - suppress ignored unless the suppress enable bit is set
// - phy side and match pins are timed in 12.5 MHz byte clocks
module emp_match_port
  import emp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // phy indicate side
  input  wire logic        byte_clock_phase_one_in,
  input  wire logic        phy_indicate_ctl_in,
  input  wire logic [7:0]  phy_indicate_bus_in,
  // external matching pins
  input  wire logic        compare_in_progress_in,
  input  wire logic        copy_frame_request_in,
  input  wire logic        destination_match_input_in,
  input  wire logic        own_source_match_in,
  input  wire logic        internal_match_suppress_in,
  // ring engine side
  input  wire logic        internal_match_in,
  input  wire logic        internal_copy_in,
  input  wire logic        resources_ok_in,
  input  wire logic        own_station_source_in,
  input  wire logic        source_address_transparency_sent_in,
  input  wire logic        own_void_frame_received_in,
  // frame results
  output logic             frame_done_out,
  output logic             frame_copy_out,
  output logic             copy_refused_out,
  output logic             address_recognised_flag_out,
  output logic             strip_start_out,
  output logic             learn_out,
  output logic             learn_valid_out,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out
);

  typedef struct packed {
    emp_frame_t  frame;
    logic        bclk_prev;
    logic        own_prev;
    logic [3:0]  hdr_cnt;
    logic        long_addr;
    logic [3:0]  info_cnt;
    logic [1:0]  tail_cnt;
    logic        cmp_idle;
    logic        cmp_seen;
    logic        cmp_fell;
    logic        cmp_done;
    logic        copy_req;
    logic        own_req;
    logic        own_hit;
    logic        supp_seen;
    logic        ext_da;
    logic [1:0]  learn_cnt;
    logic [1:0]  strip_cnt;
    logic        transp_hold;
    logic        done;
    logic        copy;
    logic        refused;
    logic        addr_flag;
    logic        strip;
    logic        learn;
    logic        learn_valid;
    logic [1:0]  ctrl;
    logic        ack;
    logic [31:0] rdata;
  } emp_core_t;

  emp_core_t s_r;
  emp_core_t s_nxt;

  emp_sync_if sif ();

  // every phy and external match pin passes two flops before the core looks at it
  assign sif.raw = {internal_match_suppress_in, own_source_match_in,
                    destination_match_input_in, copy_frame_request_in,
                    compare_in_progress_in, phy_indicate_bus_in,
                    phy_indicate_ctl_in, byte_clock_phase_one_in};

  emp_sync u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .pins       (sif.sync)
  );

  function automatic logic is_sd(input logic ctl, input logic [7:0] d);
    is_sd = ctl && (d[7:4] == SYM_SD_HI);
  endfunction : is_sd

  function automatic logic is_ed(input logic ctl, input logic [7:0] d);
    is_ed = ctl && (d[7:4] == SYM_ED_HI);
  endfunction : is_ed

  logic       stb;
  logic       ctl;
  logic [7:0] dat;
  logic       cmp_act;
  logic       in_frame;
  logic       early;
  logic       bus_req;
  logic       supp_en;

  assign stb      = sif.synced[SB_BYTE_CLK] && !s_r.bclk_prev;
  assign ctl      = sif.synced[SB_CTL];
  assign dat      = sif.synced[SB_DATA_LO +: 8];
  assign cmp_act  = sif.synced[SB_CMP] ^ s_r.cmp_idle;
  assign in_frame = (s_r.frame != FR_IDLE);
  assign early    = (s_r.frame == FR_HEADER) ||
                    ((s_r.frame == FR_INFO) && (s_r.info_cnt < INFO_LIMIT));
  assign bus_req  = avs_read_in || avs_write_in;
  assign supp_en  = s_r.ctrl[CTRL_SUPP_EN_BIT];

  always_comb begin
    s_nxt             = s_r;
    s_nxt.bclk_prev   = sif.synced[SB_BYTE_CLK];
    s_nxt.own_prev    = sif.synced[SB_OWN];
    s_nxt.done        = 1'b0;
    s_nxt.strip       = 1'b0;
    s_nxt.learn_valid = 1'b0;

    // compare handshake, judged against the level seen at frame start
    if (in_frame) begin
      if (!s_r.cmp_seen && early && cmp_act) begin
        s_nxt.cmp_seen = 1'b1;
      end
      if (s_r.cmp_seen && !s_r.cmp_fell && !cmp_act) begin
        s_nxt.cmp_fell = 1'b1;
      end
      if (s_r.cmp_fell && !s_r.cmp_done && stb) begin
        s_nxt.cmp_done = 1'b1;
        s_nxt.copy_req = sif.synced[SB_COPY];
        s_nxt.own_req  = sif.synced[SB_OWN];
      end
      if (early && sif.synced[SB_SUPP]) begin
        s_nxt.supp_seen = 1'b1;
      end
      if (sif.synced[SB_OWN] || own_station_source_in) begin
        s_nxt.own_hit = 1'b1;
      end
    end

    // byte-paced frame tracking
    if (stb) begin
      case (s_r.frame)
        FR_IDLE: begin
          if (is_sd(ctl, dat)) begin
            s_nxt.frame     = FR_HEADER;
            s_nxt.hdr_cnt   = 4'h0;
            s_nxt.info_cnt  = 4'h0;
            s_nxt.cmp_idle  = sif.synced[SB_CMP];
            s_nxt.cmp_seen  = 1'b0;
            s_nxt.cmp_fell  = 1'b0;
            s_nxt.cmp_done  = 1'b0;
            s_nxt.copy_req  = 1'b0;
            s_nxt.own_req   = 1'b0;
            s_nxt.own_hit   = 1'b0;
            s_nxt.supp_seen = 1'b0;
            s_nxt.ext_da    = 1'b0;
            s_nxt.learn     = 1'b0;
          end
        end
        FR_HEADER: begin
          if (ctl) begin
            s_nxt.frame = FR_IDLE;
          end else begin
            if (s_r.hdr_cnt == 4'h0) begin
              s_nxt.long_addr = dat[FC_LONG_BIT];
            end
            s_nxt.hdr_cnt = s_r.hdr_cnt + 4'h1;
            if ((s_r.hdr_cnt != 4'h0) && (s_r.hdr_cnt ==
                (s_r.long_addr ? HDR_LAST_LONG : HDR_LAST_SHORT))) begin
              s_nxt.frame = FR_INFO;
            end
          end
        end
        FR_INFO: begin
          if (is_ed(ctl, dat)) begin
            // ring engine sees the delimiter one byte later, so sample now
            s_nxt.frame    = FR_TAIL;
            s_nxt.tail_cnt = 2'h0;
            s_nxt.ext_da   = sif.synced[SB_DA];
          end else if (ctl) begin
            s_nxt.frame = FR_IDLE;
          end else begin
            if (s_r.info_cnt != 4'hf) begin
              s_nxt.info_cnt = s_r.info_cnt + 4'h1;
            end
            if ((s_r.info_cnt + 4'h1) == LEARN_INFO_BYTE) begin
              s_nxt.learn_cnt = LEARN_DELAY_BYTES;
            end
          end
        end
        FR_TAIL: begin
          s_nxt.tail_cnt = s_r.tail_cnt + 2'h1;
          if ((s_r.tail_cnt + 2'h1) == LATE_ED_BYTES) begin
            s_nxt.frame   = FR_IDLE;
            s_nxt.done    = 1'b1;
            // still comparing this late: give up on the frame
            s_nxt.refused = s_r.cmp_seen && !s_nxt.cmp_fell;
            if (s_r.cmp_seen) begin
              s_nxt.copy = s_nxt.cmp_done && !s_nxt.refused && resources_ok_in &&
                           (s_nxt.copy_req || (!s_r.ctrl[CTRL_EXT_COPY_BIT] &&
                           internal_copy_in));
            end else begin
              s_nxt.copy = !s_r.ctrl[CTRL_EXT_COPY_BIT] && internal_copy_in &&
                           resources_ok_in;
            end
            s_nxt.addr_flag = s_r.ext_da ||
                              (internal_match_in && !(supp_en && s_nxt.supp_seen));
          end
        end
        default: begin
          s_nxt.frame = FR_IDLE;
        end
      endcase
    end

    // learn countdown, paced by byte edges
    if (stb && (s_r.learn_cnt != 2'h0)) begin
      s_nxt.learn_cnt = s_r.learn_cnt - 2'h1;
      if (s_r.learn_cnt == 2'h1) begin
        s_nxt.learn_valid = 1'b1;
        s_nxt.learn       = s_r.long_addr && !s_nxt.own_hit;
      end
    end

    // transparent sends poison learning until our void comes home; set wins
    if (own_void_frame_received_in) begin
      s_nxt.transp_hold = 1'b0;
    end
    if (source_address_transparency_sent_in) begin
      s_nxt.transp_hold = 1'b1;
    end
    s_nxt.learn = s_nxt.learn && !s_nxt.transp_hold;

    // strip countdown restarts on every rising own-source match
    if (sif.synced[SB_OWN] && !s_r.own_prev) begin
      s_nxt.strip_cnt = STRIP_DELAY_BYTES;
    end else if (stb && (s_r.strip_cnt != 2'h0)) begin
      s_nxt.strip_cnt = s_r.strip_cnt - 2'h1;
      s_nxt.strip     = (s_r.strip_cnt == 2'h1);
    end

    // avalon slave: one wait cycle, then the answer
    s_nxt.ack = bus_req && !s_r.ack;
    if (avs_read_in && !s_r.ack) begin
      case (avs_address_in)
        REG_CTRL:   s_nxt.rdata = {30'h0, s_r.ctrl};
        REG_STATUS: s_nxt.rdata = {20'h0, s_r.frame, s_r.transp_hold, s_r.cmp_seen,
                                   s_r.cmp_done, s_r.supp_seen, s_r.learn,
                                   s_r.refused, s_r.copy, s_r.addr_flag};
        default:    s_nxt.rdata = 32'h0;
      endcase
    end
    if (avs_write_in && s_r.ack && (avs_address_in == REG_CTRL) &&
        avs_byteenable_in[0]) begin
      s_nxt.ctrl = avs_writedata_in[1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s_r       <= '0;
      s_r.frame <= FR_IDLE;
      s_r.ctrl  <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign frame_done_out              = s_r.done;
  assign frame_copy_out              = s_r.copy;
  assign copy_refused_out            = s_r.refused;
  assign address_recognised_flag_out = s_r.addr_flag;
  assign strip_start_out             = s_r.strip;
  assign learn_out                   = s_r.learn;
  assign learn_valid_out             = s_r.learn_valid;
  assign avs_readdata_out            = s_r.rdata;
  assign avs_waitrequest_out         = bus_req && !s_r.ack;

  a_sample_edge: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(s_r.cmp_done) |-> (s_r.copy_req == $past(sif.synced[SB_COPY])) &&
                           (s_r.own_req == $past(sif.synced[SB_OWN])))
    else $error("copy or own-source not taken at the sampling edge");

  a_cmp_window: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(s_r.cmp_seen) |-> ($past(s_r.info_cnt) < INFO_LIMIT))
    else $error("compare accepted after the seventh info byte");

  a_late_refuse: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (s_r.done && s_r.cmp_seen && !s_r.cmp_fell) |-> (s_r.refused && !s_r.copy))
    else $error("late compare did not refuse the frame");

  a_copy_cause: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (s_r.done && s_r.copy && s_r.cmp_seen) |-> (s_r.cmp_done && $past(resources_ok_in)))
    else $error("copy without a completed compare or resources");

  a_ed_sample: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((s_r.frame == FR_TAIL) && ($past(s_r.frame) == FR_INFO)) |->
      (s_r.ext_da == $past(sif.synced[SB_DA])))
    else $error("destination match not sampled at the delimiter byte");

  a_strip_delay: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (sif.synced[SB_OWN] && !s_r.own_prev) |-> ##[18:25] s_r.strip)
    else $error("strip did not start three byte times after own-source match");

  a_learn_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    learn_out |-> !s_r.transp_hold)
    else $error("learn asserted while transparent send is pending");

  a_learn_point: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((s_r.frame == FR_INFO) && (s_r.info_cnt == LEARN_INFO_BYTE) &&
     ($past(s_r.info_cnt) != LEARN_INFO_BYTE)) |-> ##[23:25] s_r.learn_valid)
    else $error("learn not valid three byte times after fourth info byte");

  a_suppress_gate: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (s_r.done && s_r.addr_flag) |-> (s_r.ext_da || !(supp_en && s_r.supp_seen)))
    else $error("internal match flag passed while suppressed");

  a_suppress_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (s_r.done && !supp_en && !s_r.ext_da) |-> (s_r.addr_flag == $past(internal_match_in)))
    else $error("suppress acted while disabled");

  a_bus_answer: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (bus_req && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("avalon request not answered after one wait cycle");

endmodule : emp_match_port
`default_nettype wire

// [common/emp_pkg.sv]
// constants, field positions and types shared by the external match port
package emp_pkg;

  // timing: core clock and the byte clock from the phy
  localparam int CLK_PERIOD_PS       = 10000;
  localparam int BYTE_CLK_PERIOD_PS  = 80000;
  localparam int BYTE_CYCLES         = BYTE_CLK_PERIOD_PS / CLK_PERIOD_PS;

  // bit positions inside the synchronised pin bundle
  localparam int SB_BYTE_CLK = 0;
  localparam int SB_CTL      = 1;
  localparam int SB_DATA_LO  = 2;
  localparam int SB_CMP      = 10;
  localparam int SB_COPY     = 11;
  localparam int SB_DA       = 12;
  localparam int SB_OWN      = 13;
  localparam int SB_SUPP     = 14;
  localparam int SYNC_W      = 15;

  // control symbol decode, upper nibble of a control byte
  localparam logic [3:0] SYM_SD_HI = 4'hd;
  localparam logic [3:0] SYM_ED_HI = 4'h5;

  // frame layout, counted in bytes after the starting delimiter
  localparam int         FC_LONG_BIT    = 6;
  localparam logic [3:0] HDR_LAST_LONG  = 4'hc;
  localparam logic [3:0] HDR_LAST_SHORT = 4'h4;

  // byte-time figures
  localparam logic [3:0] INFO_LIMIT        = 4'h7;
  localparam logic [3:0] LEARN_INFO_BYTE   = 4'h4;
  localparam logic [1:0] LEARN_DELAY_BYTES = 2'h3;
  localparam logic [1:0] STRIP_DELAY_BYTES = 2'h3;
  localparam logic [1:0] LATE_ED_BYTES     = 2'h2;

  // register map, byte addresses on the avalon slave
  localparam logic [3:0] REG_CTRL          = 4'h0;
  localparam logic [3:0] REG_STATUS        = 4'h4;
  localparam int         CTRL_SUPP_EN_BIT  = 0;
  localparam int         CTRL_EXT_COPY_BIT = 1;
  localparam logic [1:0] CTRL_RESET        = 2'h0;

  typedef enum logic [3:0] {
    FR_IDLE   = 4'h1,
    FR_HEADER = 4'h2,
    FR_INFO   = 4'h4,
    FR_TAIL   = 4'h8
  } emp_frame_t;

endpackage : emp_pkg

// [common/emp_sync_if.sv]
// raw and synchronised external pins between the port core and its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface emp_sync_if;
  import emp_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface : emp_sync_if
`default_nettype wire

// [rtl/emp_sync.sv]
// two-flop synchroniser bank for every pin that crosses into clock_in
`timescale 1ns/1ps
`default_nettype none
module emp_sync
  import emp_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  // pin bundle
  emp_sync_if.sync  pins
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } emp_sync_state_t;

  emp_sync_state_t s_r;
  emp_sync_state_t s_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = pins.raw;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.synced = s_r.stable;

endmodule : emp_sync
`default_nettype wire

// [dv/emp_far_model.sv]
// far-side model: phy byte stream plus external address recognition logic
`timescale 1ns/1ps
`default_nettype none
module emp_far_model
  import emp_pkg::*;
(
  // phy indicate side
  output logic       bclk_out,
  output logic       ctl_out,
  output logic [7:0] bus_out,
  // external matching pins
  output logic       cmp_out,
  output logic       copy_out,
  output logic       dest_out,
  output logic       own_out,
  output logic       supp_out
);
  localparam int HALF = BYTE_CLK_PERIOD_PS / 2000;
  time t_info4 = 0;
  time t_own   = 0;

  // the phy byte clock runs free; its phase is unrelated to clock_in
  initial begin
    bclk_out = 1'b0;
    ctl_out  = 1'b1;
    bus_out  = 8'ha0;
    cmp_out  = 1'b0;
    copy_out = 1'b0;
    dest_out = 1'b0;
    own_out  = 1'b0;
    supp_out = 1'b0;
    #3;
    forever #HALF bclk_out = ~bclk_out;
  end

  // bytes change on the falling edge so they stand across the strobe
  task automatic put(input logic c, input logic [7:0] b);
    @(negedge bclk_out);
    ctl_out = c;
    bus_out = b;
  endtask : put

  // rise and fall count info bytes; 0 means never within the frame
  task automatic send_frame(input logic lng, input logic pol, input int rise, input int fall,
                            input logic cp, input logic dm, input logic om, input logic sp);
    cmp_out  = pol;
    copy_out = cp;
    dest_out = dm;
    supp_out = sp;
    put(1'b1, 8'hd0);
    put(1'b0, lng ? 8'h40 : 8'h00);
    repeat (lng ? 12 : 4) put(1'b0, 8'h3c);
    for (int i = 1; i <= 10; i++) begin
      put(1'b0, 8'(i));
      if (i == 4) t_info4 = $time + HALF;
      if (i == 2 && om) begin
        own_out = 1'b1;
        t_own   = $time;
      end
      if (i == rise) cmp_out = ~pol;
      if (i == fall) cmp_out = pol;
    end
    put(1'b1, 8'h55);
    repeat (6) put(1'b1, 8'ha0);
    cmp_out = pol;  // back to idle only once the six gap bytes are out
    own_out = 1'b0;
  endtask : send_frame
endmodule : emp_far_model
`default_nettype wire

// [dv/emp_match_port_tb.sv]
// self-checking bench for the external match port
`timescale 1ns/1ps
`default_nettype none
module emp_match_port_tb
  import emp_pkg::*;
;
  logic        clock_in, bclk, ctl, cmp, cp, dm, om, sp;
  logic        sys_rst_in = 1'b1, imatch = 1'b0, icopy = 1'b0, res_ok = 1'b1;
  logic        own_sta = 1'b0, transp_sent = 1'b0, own_void = 1'b0;
  logic        done, fcopy, refused, addr_flag, strip, learn, lvalid, avs_waitrequest;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [7:0]  pbus;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  int          mismatches = 0, cmp_count = 0, lv_hits = 0, strip_hits = 0;
  time         t_lv = 0, t_strip = 0;

  emp_far_model u_far (.bclk_out(bclk), .ctl_out(ctl), .bus_out(pbus), .cmp_out(cmp),
    .copy_out(cp), .dest_out(dm), .own_out(om), .supp_out(sp));

  emp_match_port u_dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .byte_clock_phase_one_in(bclk),
    .phy_indicate_ctl_in(ctl), .phy_indicate_bus_in(pbus), .compare_in_progress_in(cmp),
    .copy_frame_request_in(cp), .destination_match_input_in(dm), .own_source_match_in(om),
    .internal_match_suppress_in(sp), .internal_match_in(imatch), .internal_copy_in(icopy),
    .resources_ok_in(res_ok), .own_station_source_in(own_sta),
    .source_address_transparency_sent_in(transp_sent), .own_void_frame_received_in(own_void),
    .frame_done_out(done), .frame_copy_out(fcopy), .copy_refused_out(refused),
    .address_recognised_flag_out(addr_flag), .strip_start_out(strip), .learn_out(learn),
    .learn_valid_out(lvalid), .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // one-cycle pulses are sampled mid-cycle, clear of the launching edge
  always @(negedge clock_in) begin
    if (lvalid === 1'b1) begin
      lv_hits++;
      t_lv = $time;
    end
    if (strip === 1'b1) begin
      strip_hits++;
      t_strip = $time;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // holds the request until waitrequest is seen low at a rising edge; data taken there
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic ws;
    int   n;
    n = 0;
    @(posedge clock_in);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clock_in);
      ws = avs_waitrequest;
      n++;
    end while (ws !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check(ws, 1'b0, "bus answer");
  endtask : bus_xfer

  // v = {internal match, internal copy, resources, own station}
  task automatic ring(input logic [3:0] v, input logic [1:0] ctrl);
    @(posedge clock_in);
    {imatch, icopy, res_ok, own_sta} <= v;
    bus_xfer(1'b1, REG_CTRL, {30'h0, ctrl});
  endtask : ring

  task automatic pulse(input logic v);
    @(posedge clock_in);
    transp_sent <= v;
    own_void    <= ~v;
    @(posedge clock_in);
    transp_sent <= 1'b0;
    own_void    <= 1'b0;
  endtask : pulse

  // exp = {learn, refused, copy, address flag}, same order as status[3:0]
  task automatic run_frame(input string nm, input logic lng, input logic pol, input int rise,
                           input int fall, input logic c, input logic m, input logic o,
                           input logic s, input logic [3:0] exp);
    int n;
    n = 0;
    lv_hits = 0;
    strip_hits = 0;
    fork
      u_far.send_frame(lng, pol, rise, fall, c, m, o, s);
      while (done !== 1'b1 && n < 2000) begin
        @(negedge clock_in);
        n++;
      end
    join
    check({31'h0, n < 2000}, 32'h1, "frame done");
    check({learn, refused, fcopy, addr_flag}, exp, "frame result");
    bus_xfer(1'b0, REG_STATUS, 32'h0);
    check(rd[3:0], exp, "status bits");
    check(lv_hits, 32'h1, "learn valid pulses");
    check({31'h0, t_lv - u_far.t_info4 inside {[240:310]}}, 32'h1, "learn timing");
    check(strip_hits, o, "strip pulses");
    if (o) check({31'h0, t_strip - u_far.t_own inside {[200:300]}}, 32'h1, "strip timing");
    $display("test %s done", nm);
  endtask : run_frame

  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    bus_xfer(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    bus_xfer(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0, "unmapped read");
    ring(4'b0110, 2'h0);
    run_frame("plain long", 1, 0, 0, 0, 0, 0, 0, 0, 4'ha);
    ring(4'b0010, 2'h2);
    run_frame("ext copy high", 1, 0, 1, 5, 1, 0, 1, 0, 4'h2);
    run_frame("ext copy low", 1, 1, 1, 5, 1, 0, 1, 0, 4'h2);
    run_frame("ext no copy", 1, 0, 1, 5, 0, 0, 0, 0, 4'h8);
    ring(4'b0000, 2'h2);
    run_frame("no resources", 1, 0, 1, 5, 1, 0, 0, 0, 4'h8);
    ring(4'b0110, 2'h0);
    run_frame("compare past end", 1, 0, 6, 0, 1, 0, 0, 0, 4'hc);
    run_frame("late raise", 1, 0, 8, 0, 0, 0, 0, 0, 4'ha);
    run_frame("dest match", 1, 0, 0, 0, 0, 1, 0, 0, 4'hb);
    ring(4'b1110, 2'h1);
    run_frame("suppress on", 1, 0, 0, 0, 0, 0, 0, 1, 4'ha);
    ring(4'b1110, 2'h0);
    run_frame("suppress off", 1, 0, 0, 0, 0, 0, 0, 1, 4'hb);
    ring(4'b0110, 2'h0);
    run_frame("short", 0, 0, 0, 0, 0, 0, 0, 0, 4'h2);
    ring(4'b0111, 2'h0);
    run_frame("own station", 1, 0, 0, 0, 0, 0, 0, 0, 4'h2);
    ring(4'b0110, 2'h0);
    pulse(1'b1);
    run_frame("hold set", 1, 0, 0, 0, 0, 0, 0, 0, 4'h2);
    pulse(1'b0);
    run_frame("hold cleared", 1, 0, 0, 0, 0, 0, 0, 0, 4'ha);
    report_and_stop();
  end

  // fourteen frames of about 2.5 us each; generous margin on top
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule : emp_match_port_tb
`default_nettype wire
